/* File: tb/scmc_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// port watcher for the clock and mode controller
module scmc_checker
  import scmc_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  // options and events
  input wire logic [1:0]  cfg_hs_type,
  input wire logic        cfg_dedicated_pins,
  input wire logic        cfg_slow_rc_disable,
  input wire logic        halt_req,
  input wire logic        wake_req,
  // oscillator and clock outputs
  input wire logic        internal_fast_rc_osc_en,
  input wire logic        fast_crystal_osc_en,
  input wire logic        external_rc_osc_en,
  input wire logic        low_speed_crystal_osc_en,
  input wire logic        crystal_low_power_sel,
  input wire logic        internal_slow_rc_osc_en,
  input wire logic        sys_hs_gate,
  input wire logic        sys_ls_gate,
  input wire logic        sys_clk_run,
  input wire logic [1:0]  op_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // properties
  property p_gates_excl; !(sys_hs_gate && sys_ls_gate); endproperty
  property p_switch_gap;
    op_mode == SCMC_MODE_SLOW && $fell(sys_hs_gate) |->
      !sys_ls_gate ##1 !sys_ls_gate ##[1:3] sys_ls_gate;
  endproperty
  property p_clk_stop;
    op_mode[1] |-> !sys_clk_run && !sys_hs_gate && !sys_ls_gate;
  endproperty
  // enables are registered, so allow one cycle after the mode change
  property p_hs_off;
    op_mode[1] && $past(op_mode[1]) |->
      !(internal_fast_rc_osc_en || fast_crystal_osc_en || external_rc_osc_en);
  endproperty
  property p_halt; halt_req && clk_en && !op_mode[1] |=> op_mode[1]; endproperty
  property p_wake; wake_req && clk_en && op_mode[1] |=> !op_mode[1]; endproperty
  property p_slow_rc;
    nrst && clk_en |=> internal_slow_rc_osc_en == !$past(cfg_slow_rc_disable);
  endproperty
  property p_low_power;
    psel && penable && pwrite && clk_en && paddr == 32'h0 |=>
      crystal_low_power_sel == $past(pwdata[1]);
  endproperty
  property p_shared_lxt;
    clk_en && !cfg_dedicated_pins && cfg_hs_type != SCMC_HS_FAST_RC |=> !low_speed_crystal_osc_en;
  endproperty

  // ==========================================================
  // assertions
  a_gates_excl: assert property (p_gates_excl) else $error("both clock gates open");
  a_switch_gap: assert property (p_switch_gap) else $error("no dead gap on switch");
  a_clk_stop: assert property (p_clk_stop) else $error("clock runs while halted");
  a_hs_off: assert property (p_hs_off) else $error("fast source on while halted");
  a_halt: assert property (p_halt) else $error("halt not taken");
  a_wake: assert property (p_wake) else $error("wake not taken");
  a_slow_rc: assert property (p_slow_rc) else $error("slow rc enable wrong");
  a_low_power: assert property (p_low_power) else $error("low power bit wrong");
  a_shared_lxt: assert property (p_shared_lxt) else $error("crystal with shared pins");

  // ==========================================================
  // main scenarios
  c_idle: cover property (halt_req ##1 op_mode == SCMC_MODE_IDLE);
  c_sleep: cover property (halt_req ##1 op_mode == SCMC_MODE_SLEEP);
  c_to_low: cover property ($rose(sys_ls_gate));
endmodule // scmc_checker

bind scmc_top scmc_checker i_chk (
  .ref_clk, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
  .cfg_hs_type, .cfg_dedicated_pins, .cfg_slow_rc_disable, .halt_req, .wake_req,
  .internal_fast_rc_osc_en, .fast_crystal_osc_en, .external_rc_osc_en,
  .low_speed_crystal_osc_en, .crystal_low_power_sel, .internal_slow_rc_osc_en,
  .sys_hs_gate, .sys_ls_gate, .sys_clk_run, .op_mode
);

/* File: tb/tb_system_clock_mode_control.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_system_clock_mode_control
  import scmc_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  logic        ref_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, prdata;
  logic        pready, pslverr, err;
  logic [1:0]  cfg_hs_type = 2'h0, cfg_fast_rc_freq = 2'h0;
  logic        cfg_lxt_enable = 1'b1, cfg_dedicated_pins = 1'b0, cfg_slow_rc_disable = 1'b0;
  logic        halt_req = 1'b0, wake_req = 1'b0;
  logic        internal_fast_rc_osc_en, fast_crystal_osc_en, external_rc_osc_en;
  logic        low_speed_crystal_osc_en, crystal_low_power_sel, internal_slow_rc_osc_en;
  logic        sys_hs_gate, sys_ls_gate, sys_clk_run;
  logic        porta_bit5_gpio, porta_bit6_gpio, slow_crystal_pins_gpio;
  logic [1:0]  internal_fast_rc_osc_freq, op_mode;
  int          fail_count = 0, checks_done = 0, cyc = 0;

  scmc_top i_dut (
    .ref_clk, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg_hs_type, .cfg_fast_rc_freq, .cfg_lxt_enable,
    .cfg_dedicated_pins, .cfg_slow_rc_disable, .halt_req, .wake_req,
    .internal_fast_rc_osc_en, .internal_fast_rc_osc_freq, .fast_crystal_osc_en,
    .external_rc_osc_en, .low_speed_crystal_osc_en, .crystal_low_power_sel,
    .internal_slow_rc_osc_en, .sys_hs_gate, .sys_ls_gate, .sys_clk_run, .op_mode,
    .porta_bit5_gpio, .porta_bit6_gpio, .slow_crystal_pins_gpio
  );

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // ==========================================================
  // tasks
  task conclude();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer; the answer is taken only at the edge with pready high
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // wait long enough for the switch gap and the registered enables
  task settle();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  // one-cycle halt or wake pulse
  task ev(input logic h);
    @(posedge ref_clk);
    if (h) halt_req <= 1'b1; else wake_req <= 1'b1;
    @(posedge ref_clk);
    halt_req <= 1'b0; wake_req <= 1'b0;
    settle();
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      conclude();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, 32'h0, 32'h0); `CHK("control_reg_zero", 32'h0, rd)
    apb(1'b0, 32'h4, 32'h0); `CHK("control_reg_two", 32'h1, rd)
    `CHK("low_power", 1'b0, crystal_low_power_sel)
    for (int f = 0; f < 3; f++) begin
      @(posedge ref_clk); cfg_fast_rc_freq <= 2'(f); #1;
      `CHK("freq", 2'(f), internal_fast_rc_osc_freq)
    end
    // shared pins with the crystal fitted: it holds both main pins beside the fast RC
    for (int t = 0; t < 3; t++) begin
      @(posedge ref_clk); cfg_hs_type <= 2'(t); settle();
      `CHK("pa5", t == 2, porta_bit5_gpio)
      `CHK("pa6", 1'b0, porta_bit6_gpio)
      `CHK("lxt", t == 0, low_speed_crystal_osc_en)
      `CHK("erc", t == 2, external_rc_osc_en)
    end
    // external rc: source bit must have no effect
    apb(1'b1, 32'h0, 32'h1); settle();
    `CHK("mode", SCMC_MODE_NORMAL, op_mode)
    `CHK("hs_gate", 1'b1, sys_hs_gate)
    apb(1'b1, 32'h0, 32'h0);
    @(posedge ref_clk); cfg_hs_type <= SCMC_HS_FAST_RC; settle();
    apb(1'b1, 32'h0, 32'h2); settle();
    `CHK("low_power", 1'b1, crystal_low_power_sel)
    `CHK("lxt", 1'b1, low_speed_crystal_osc_en)
    apb(1'b0, 32'h0, 32'h0); `CHK("control_reg_zero", 32'h2, rd)
    // switch to the low clock, then halt and wake there
    apb(1'b1, 32'h0, 32'h3); settle();
    `CHK("mode", SCMC_MODE_SLOW, op_mode)
    `CHK("ls_gate", 1'b1, sys_ls_gate)
    `CHK("fast_rc", 1'b0, internal_fast_rc_osc_en)
    apb(1'b0, 32'h8, 32'h0); `CHK("status", 32'h35, rd)
    ev(1'b1); `CHK("mode", SCMC_MODE_IDLE, op_mode)
    `CHK("clk_run", 1'b0, sys_clk_run)
    `CHK("lxt", 1'b1, low_speed_crystal_osc_en)
    `CHK("slow_rc", 1'b1, internal_slow_rc_osc_en)
    ev(1'b0); `CHK("mode", SCMC_MODE_SLOW, op_mode)
    apb(1'b1, 32'h0, 32'h2); settle();
    `CHK("mode", SCMC_MODE_NORMAL, op_mode)
    `CHK("fast_rc", 1'b1, internal_fast_rc_osc_en)
    // dedicated pins with the fast crystal
    @(posedge ref_clk); cfg_dedicated_pins <= 1'b1; cfg_hs_type <= SCMC_HS_FAST_XTAL; settle();
    `CHK("lxt", 1'b1, low_speed_crystal_osc_en)
    `CHK("hxt", 1'b1, fast_crystal_osc_en)
    `CHK("xt_gpio", 1'b0, slow_crystal_pins_gpio)
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 32'h4, 32'(k)); ev(1'b1);
      `CHK("mode", k ? SCMC_MODE_IDLE : SCMC_MODE_SLEEP, op_mode)
      `CHK("lxt", k == 1, low_speed_crystal_osc_en)
      `CHK("hxt", 1'b0, fast_crystal_osc_en)
      ev(1'b0); `CHK("mode", SCMC_MODE_NORMAL, op_mode)
    end
    @(posedge ref_clk); cfg_lxt_enable <= 1'b0; cfg_slow_rc_disable <= 1'b1;
    cfg_hs_type <= SCMC_HS_FAST_RC; settle();
    `CHK("xt_gpio", 1'b1, slow_crystal_pins_gpio)
    `CHK("pa5", 1'b1, porta_bit5_gpio)
    `CHK("pa6", 1'b1, porta_bit6_gpio)
    `CHK("slow_rc", 1'b0, internal_slow_rc_osc_en)
    // unmapped place is refused
    apb(1'b0, 32'h10, 32'h0); `CHK("err", 1'b1, err)
    `CHK("rd", 32'h0, rd)
    // second reset in mid-run clears the low-power bit and sets keep-on again
    apb(1'b1, 32'h4, 32'h0);
    @(posedge ref_clk); nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, 32'h0, 32'h0); `CHK("control_reg_zero", 32'h0, rd)
    `CHK("low_power", 1'b0, crystal_low_power_sel)
    apb(1'b0, 32'h4, 32'h0); `CHK("control_reg_two", 32'h1, rd)
    conclude();
  end
endmodule // tb_system_clock_mode_control

/* File: verilog/scmc_clk_switch.sv */
`timescale 1ns/1ps
`include "scmc_defines.svh"

module scmc_clk_switch
  import scmc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // control side
  scmc_sw_if.sw    sw
);

  localparam logic [3:0] GAP = 4'(`SCMC_SWITCH_GAP_CYC);

  scmc_sw_type s_reg;
  scmc_sw_type s_next;

  // ==========================================================
  // break before make: the old gate drops, a dead gap passes, then
  // the new gate opens, so no shortened pulse reaches the system clock
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      SCMC_SW_HS: begin
        if (sw.want_low) begin
          s_next.st      = SCMC_SW_TO_LS;
          s_next.hs_gate = 1'b0;
          s_next.cnt     = GAP;
        end
      end
      SCMC_SW_TO_LS: begin
        if (s_reg.cnt > 4'h1) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else begin
          s_next.st      = SCMC_SW_LS;
          s_next.ls_gate = 1'b1;
        end
      end
      SCMC_SW_LS: begin
        if (!sw.want_low) begin
          s_next.st      = SCMC_SW_TO_HS;
          s_next.ls_gate = 1'b0;
          s_next.cnt     = GAP;
        end
      end
      SCMC_SW_TO_HS: begin
        if (s_reg.cnt > 4'h1) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else begin
          s_next.st      = SCMC_SW_HS;
          s_next.hs_gate = 1'b1;
        end
      end
      default: begin
        s_next = '{st: SCMC_SW_HS, cnt: 4'h0, hs_gate: 1'b1, ls_gate: 1'b0};
      end
    endcase
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '{st: SCMC_SW_HS, cnt: 4'h0, hs_gate: 1'b1, ls_gate: 1'b0};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // fast oscillator must run while it is gated in or about to be
  assign sw.hs_gate   = s_reg.hs_gate;
  assign sw.ls_gate   = s_reg.ls_gate;
  assign sw.hs_needed = (s_reg.st == SCMC_SW_HS) || (s_reg.st == SCMC_SW_TO_HS);

endmodule // scmc_clk_switch

/* File: verilog/scmc_defines.svh */
`ifndef SCMC_DEFINES_SVH
`define SCMC_DEFINES_SVH

// ==========================================================
// register byte offsets
`define SCMC_OFF_CTRL_ZERO     8'h00
`define SCMC_OFF_CTRL_TWO      8'h04
`define SCMC_OFF_STATUS        8'h08

// ==========================================================
// control_reg_zero fields
`define SCMC_BIT_SRC_SEL       0
`define SCMC_BIT_LOW_POWER     1
// control_reg_two fields
`define SCMC_BIT_KEEP_ON       0

// ==========================================================
// status register fields
`define SCMC_ST_MODE_LSB       0
`define SCMC_ST_MODE_MSB       1
`define SCMC_ST_ON_LOW         2
`define SCMC_ST_HS_RUN         3
`define SCMC_ST_LXT_RUN        4
`define SCMC_ST_LXT_CFG        5

// ==========================================================
// power-on values
`define SCMC_RST_SRC_SEL       1'h0
`define SCMC_RST_LOW_POWER     1'h0
`define SCMC_RST_KEEP_ON       1'h1

// ==========================================================
// timing: dead time between old and new clock gate
`define SCMC_CLK_PERIOD_NS     50
`define SCMC_SWITCH_GAP_NS     100
`define SCMC_SWITCH_GAP_CYC    ((`SCMC_SWITCH_GAP_NS + `SCMC_CLK_PERIOD_NS - 1) / `SCMC_CLK_PERIOD_NS)

`endif

/* File: verilog/scmc_pkg.sv */
package scmc_pkg;

  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    SCMC_MODE_NORMAL = 2'h0,
    SCMC_MODE_SLOW   = 2'h1,
    SCMC_MODE_IDLE   = 2'h2,
    SCMC_MODE_SLEEP  = 2'h3
  } scmc_mode_type;

  // high-speed oscillator configuration option
  typedef enum logic [1:0] {
    SCMC_HS_FAST_RC   = 2'h0,
    SCMC_HS_FAST_XTAL = 2'h1,
    SCMC_HS_EXT_RC    = 2'h2
  } scmc_hs_type;

  // clock switch states
  typedef enum logic [1:0] {
    SCMC_SW_HS    = 2'h0,
    SCMC_SW_TO_LS = 2'h1,
    SCMC_SW_LS    = 2'h2,
    SCMC_SW_TO_HS = 2'h3
  } scmc_sw_state_type;

  // ==========================================================
  // clock switch state
  typedef struct packed {
    scmc_sw_state_type st;
    logic [3:0]        cnt;
    logic              hs_gate;
    logic              ls_gate;
  } scmc_sw_type;

  // top state
  typedef struct packed {
    logic          src_sel;
    logic          low_power;
    logic          keep_on;
    scmc_mode_type mode;
    logic [31:0]   prdata;
    logic          pslverr;
    logic          fast_rc_en;
    logic          fast_xtal_en;
    logic          ext_rc_en;
    logic          lxt_en;
    logic          slow_rc_en;
    logic          pa5_gpio;
    logic          pa6_gpio;
    logic          xtal_gpio;
  } scmc_top_type;

endpackage

/* File: verilog/scmc_sw_if.sv */
`timescale 1ns/1ps
interface scmc_sw_if;
  logic want_low;
  logic hs_gate;
  logic ls_gate;
  logic hs_needed;

  // ==========================================================
  modport ctrl (output want_low, input hs_gate, ls_gate, hs_needed);
  modport sw   (input want_low, output hs_gate, ls_gate, hs_needed);
endinterface

/* File: verilog/scmc_top.sv */
`timescale 1ns/1ps
`include "scmc_defines.svh"

module scmc_top
  import scmc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // configuration options
  input  wire logic [1:0]  cfg_hs_type,
  input  wire logic [1:0]  cfg_fast_rc_freq,
  input  wire logic        cfg_lxt_enable,
  input  wire logic        cfg_dedicated_pins,
  input  wire logic        cfg_slow_rc_disable,
  // core events
  input  wire logic        halt_req,
  input  wire logic        wake_req,
  // oscillator controls
  output logic             internal_fast_rc_osc_en,
  output logic [1:0]       internal_fast_rc_osc_freq,
  output logic             fast_crystal_osc_en,
  output logic             external_rc_osc_en,
  output logic             low_speed_crystal_osc_en,
  output logic             crystal_low_power_sel,
  output logic             internal_slow_rc_osc_en,
  // system clock gates and mode
  output logic             sys_hs_gate,
  output logic             sys_ls_gate,
  output logic             sys_clk_run,
  output logic [1:0]       op_mode,
  // pin ownership
  output logic             porta_bit5_gpio,
  output logic             porta_bit6_gpio,
  output logic             slow_crystal_pins_gpio
);

  // ==========================================================
  // declarations
  scmc_top_type  t_reg;
  scmc_top_type  t_next;
  scmc_sw_if     sw_if ();

  logic          lxt_cfg;
  logic          eff_sel;
  logic          halted;
  logic          lxt_after_halt;
  logic          hs_run;
  logic          lxt_run;
  logic          is_fast_rc;
  logic          wr_en;
  logic          rd_setup;
  logic [7:0]    addr_lo;
  logic          addr_hit;
  logic [31:0]   rd_mux;
  logic [31:0]   status_word;
  logic          lxt_on_main;
  logic          pa5_free;
  logic          pa6_free;
  scmc_mode_type run_mode;
  scmc_mode_type halt_mode;

  // ==========================================================
  // configuration decode
  // crystal is usable on shared pins only beside the fast RC
  assign is_fast_rc = (cfg_hs_type == SCMC_HS_FAST_RC);
  assign lxt_cfg    = cfg_lxt_enable && (cfg_dedicated_pins || is_fast_rc);

  // source bit only counts where the crystal is actually fitted
  assign eff_sel = t_reg.src_sel && lxt_cfg;

  // crystal state after halt: always on shared pins, bit-steered otherwise
  assign lxt_after_halt = lxt_cfg && (!cfg_dedicated_pins || t_reg.keep_on);

  assign halted = (t_reg.mode == SCMC_MODE_IDLE) || (t_reg.mode == SCMC_MODE_SLEEP);

  // ==========================================================
  // mode targets
  // the running mode follows the effective source bit; a halt lands
  // in Idle when the crystal stays up and in Sleep when it stops
  assign run_mode  = eff_sel ? SCMC_MODE_SLOW : SCMC_MODE_NORMAL;
  assign halt_mode = lxt_after_halt ? SCMC_MODE_IDLE : SCMC_MODE_SLEEP;

  // ==========================================================
  // pin ownership
  // on shared pins a fitted crystal sits on both main oscillator pins,
  // so they stay with the oscillator even beside the fast RC
  assign lxt_on_main = lxt_cfg && !cfg_dedicated_pins;
  // external RC drives only one main pin, which leaves the other free
  assign pa5_free = (is_fast_rc && !lxt_on_main) || (cfg_hs_type == SCMC_HS_EXT_RC);
  assign pa6_free = is_fast_rc && !lxt_on_main;

  // ==========================================================
  // oscillator run conditions
  // fast source keeps running until the switch has left it, so the
  // gate never closes on a clock that has already died
  assign hs_run  = !halted && (!eff_sel || sw_if.hs_needed);
  // crystal runs in Normal, Slow and Idle, stopped only in Sleep
  assign lxt_run = lxt_cfg && (!halted || (t_reg.mode == SCMC_MODE_IDLE));

  // ==========================================================
  // clock switch hookup
  // the switch sees the effective bit, so an ignored source write never moves it
  assign sw_if.want_low = eff_sel;

  scmc_clk_switch u_switch (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .sw      (sw_if.sw)
  );

  // ==========================================================
  // apb decode
  // zero-wait slave: reads are captured in the setup cycle so prdata
  // comes from a flop; writes take effect at the access edge
  assign addr_lo  = paddr[7:0];
  assign addr_hit = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) &&
                    ((addr_lo == `SCMC_OFF_CTRL_ZERO) ||
                     (addr_lo == `SCMC_OFF_CTRL_TWO) ||
                     (addr_lo == `SCMC_OFF_STATUS));
  // an unmapped or misaligned place answers with pslverr and reads zero;
  // a write to it is dropped, so a stray store cannot disturb the clocks
  assign rd_setup = psel && !penable;
  assign wr_en    = psel && penable && pwrite && addr_hit;

  // ==========================================================
  // status word: live view of mode, the switch's low-clock gate and oscillators
  always_comb begin
    status_word = 32'h00000000;
    status_word[`SCMC_ST_MODE_MSB:`SCMC_ST_MODE_LSB] = t_reg.mode;
    status_word[`SCMC_ST_ON_LOW]  = sw_if.ls_gate;
    status_word[`SCMC_ST_HS_RUN]  = hs_run;
    status_word[`SCMC_ST_LXT_RUN] = lxt_run;
    status_word[`SCMC_ST_LXT_CFG] = lxt_cfg;
  end

  // read data multiplexer; unused bits read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (addr_hit) begin
      case (addr_lo)
        `SCMC_OFF_CTRL_ZERO: begin
          rd_mux[`SCMC_BIT_SRC_SEL]   = t_reg.src_sel;
          rd_mux[`SCMC_BIT_LOW_POWER] = t_reg.low_power;
        end
        `SCMC_OFF_CTRL_TWO: begin
          rd_mux[`SCMC_BIT_KEEP_ON] = t_reg.keep_on;
        end
        `SCMC_OFF_STATUS: begin
          rd_mux = status_word;
        end
        default: begin
          rd_mux = 32'h00000000;
        end
      endcase
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    t_next = t_reg;

    // bus capture of read data and error
    if (rd_setup) begin
      t_next.prdata  = pwrite ? 32'h00000000 : rd_mux;
      t_next.pslverr = !addr_hit;
    end

    // register writes; status is read only and ignores writes
    if (wr_en) begin
      case (addr_lo)
        `SCMC_OFF_CTRL_ZERO: begin
          t_next.src_sel   = pwdata[`SCMC_BIT_SRC_SEL];
          t_next.low_power = pwdata[`SCMC_BIT_LOW_POWER];
        end
        `SCMC_OFF_CTRL_TWO: begin
          // on shared pins the bit is absent and reads back as written
          // but has no effect on the crystal
          t_next.keep_on = pwdata[`SCMC_BIT_KEEP_ON];
        end
        default: begin
          t_next.keep_on = t_reg.keep_on;
        end
      endcase
    end

    // mode sequencing: halt is independent of the source bit
    // halt_req is ignored once halted, wake_req while running
    case (t_reg.mode)
      SCMC_MODE_NORMAL, SCMC_MODE_SLOW: begin
        if (halt_req) begin
          t_next.mode = halt_mode;
        end else begin
          t_next.mode = run_mode;
        end
      end
      SCMC_MODE_IDLE, SCMC_MODE_SLEEP: begin
        // a wake returns to the mode picked by the source bit
        if (wake_req) begin
          t_next.mode = run_mode;
        end
      end
      default: begin
        t_next.mode = SCMC_MODE_NORMAL;
      end
    endcase

    // oscillator enables, registered for clean analog controls
    t_next.fast_rc_en   = hs_run && is_fast_rc;
    t_next.fast_xtal_en = hs_run && (cfg_hs_type == SCMC_HS_FAST_XTAL);
    t_next.ext_rc_en    = hs_run && (cfg_hs_type == SCMC_HS_EXT_RC);
    t_next.lxt_en       = lxt_run;
    // slow RC follows only its option, so a halt never stops the watchdog clock
    t_next.slow_rc_en   = !cfg_slow_rc_disable;

    // pin ownership, registered so a pin never changes owner mid-cycle
    t_next.pa5_gpio  = pa5_free;
    t_next.pa6_gpio  = pa6_free;
    t_next.xtal_gpio = cfg_dedicated_pins && !cfg_lxt_enable;
  end

  // ==========================================================
  // state register; power-on values, frozen while clk_en is low
  // fields reset one by one so each power-on value reads plainly;
  // a low clk_en also holds off bus writes, so software must not write then
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      t_reg.src_sel      <= `SCMC_RST_SRC_SEL;
      t_reg.low_power    <= `SCMC_RST_LOW_POWER;
      t_reg.keep_on      <= `SCMC_RST_KEEP_ON;
      t_reg.mode         <= SCMC_MODE_NORMAL;
      t_reg.prdata       <= 32'h00000000;
      t_reg.pslverr      <= 1'b0;
      t_reg.fast_rc_en   <= 1'b0;
      t_reg.fast_xtal_en <= 1'b0;
      t_reg.ext_rc_en    <= 1'b0;
      t_reg.lxt_en       <= 1'b0;
      t_reg.slow_rc_en   <= 1'b0;
      t_reg.pa5_gpio     <= 1'b0;
      t_reg.pa6_gpio     <= 1'b0;
      t_reg.xtal_gpio    <= 1'b0;
    end else if (clk_en) begin
      t_reg <= t_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata  = t_reg.prdata;
  assign pslverr = t_reg.pslverr;
  assign pready  = 1'b1; // never stalls: every register is a flop

  // oscillator controls; the frequency code is a static option, passed on
  assign internal_fast_rc_osc_en   = t_reg.fast_rc_en;
  assign internal_fast_rc_osc_freq = cfg_fast_rc_freq;
  assign fast_crystal_osc_en       = t_reg.fast_xtal_en;
  assign external_rc_osc_en        = t_reg.ext_rc_en;
  assign low_speed_crystal_osc_en  = t_reg.lxt_en;
  // low-power bit only trims drive; it never gates the crystal
  assign crystal_low_power_sel     = t_reg.low_power;
  assign internal_slow_rc_osc_en   = t_reg.slow_rc_en;

  // gates close while halted so the system clock stops
  assign sys_hs_gate = sw_if.hs_gate && !halted;
  assign sys_ls_gate = sw_if.ls_gate && !halted;
  assign sys_clk_run = !halted;
  assign op_mode     = t_reg.mode;

  // pin ownership: 1 hands the pin to the port logic
  assign porta_bit5_gpio        = t_reg.pa5_gpio;
  assign porta_bit6_gpio        = t_reg.pa6_gpio;
  assign slow_crystal_pins_gpio = t_reg.xtal_gpio;

endmodule // scmc_top
